// File: design/mss_top.sv
// module-wide state sequencer with APB register access
// assumes lane path states come from logic on pclk; pins are asynchronous
//
// Operation
// RULE1 - changed notice is set only on entering fault, low-power or ready
// RULE2 - no notice when the entered state's exit condition already holds
// RULE3 - start in reset, stay while reset condition true, then interface init
// RULE4 - exit priority: reset first, fault second, all others last
// RULE5 - reset condition is supply reset OR reset pin OR soft reset bit
// RULE6 - supply reset is optional and reads as deasserted when absent
// RULE7 - host holds the reset pin beyond the minimum pulse duration
// RULE8 - fault condition comes from enabled internal fault sources
// RULE9 - low power when software bit set, or permit bit and pin asserted
// RULE10 - ready exits to powering down on low power and all paths deactivated
// RULE11 - all paths deactivated only when every lane shows the deactivated state
// RULE12 - reset condition sends any state to resetting; fault goes to fault (code: reset stays in reset; resetting and reset ignore fault)
// RULE13 - low power leaves when condition drops; powering up ends ready or down
// RULE14 - ready goes powering down on exit condition, then back to low power
// RULE15 - transitions clear no flags; interrupt clears only by clear or mask
// RULE16 - conditions evaluated and state registered every clock, state readable
`timescale 1ns/1ps
module mss_top #(
	parameter bit HAS_SUPPLY_RESET = 1'b1
) (
	// clock and reset
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	// apb slave
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [7:0]                            paddr,
	input  wire logic [31:0]                           pwdata,
	output logic      [31:0]                           prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	// host pins
	input  wire logic                                  hw_reset_n,
	input  wire logic                                  low_power_pin,
	// internal sources
	input  wire logic                                  supply_reset,
	input  wire logic [mss_pkg::FAULT_W-1:0]           fault_src,
	input  wire logic [mss_pkg::LANES-1:0][mss_pkg::PATH_W-1:0] lane_path_state,
	// status out
	output logic      [2:0]                            module_state,
	output logic                                       irq
);

	// ----------------------------------------------------------------
	// pin and internal source synchronisers
	// ----------------------------------------------------------------
	// reset pin reset_condition to asserted: reset is left only once the pin is seen high
	logic       hw_reset_n_s;
	logic       low_power_pin_s;
	logic       supply_reset_s;
	logic [mss_pkg::FAULT_W-1:0] fault_s;

	mss_sync #(
		.W    (3),
		.INIT (32'h0000_0000)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({supply_reset, low_power_pin, hw_reset_n}),
		.sync_out ({supply_reset_s, low_power_pin_s, hw_reset_n_s})
	);

	mss_sync #(
		.W    (mss_pkg::FAULT_W),
		.INIT (32'h0000_0000)
	) u_fault_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (fault_src),
		.sync_out (fault_s)
	);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0]                 ctrl_r;
	logic [mss_pkg::INT_W-1:0]   int_status_r;
	logic [mss_pkg::INT_W-1:0]   int_enable_r;
	mss_pkg::mss_state_t         state_r;
	mss_pkg::mss_state_t         state_nxt;
	logic                        entered_r;
	logic                        fault_cond_q_r;
	logic soft_reset;
	logic sw_lp_req_bit;
	logic pin_low_power_permit;
	logic [mss_pkg::FAULT_W-1:0] fault_enable;
	assign soft_reset           = ctrl_r[mss_pkg::CTRL_SOFT_RESET];
	assign sw_lp_req_bit        = ctrl_r[mss_pkg::CTRL_SW_LP];
	assign pin_low_power_permit = ctrl_r[mss_pkg::CTRL_LP_PERMIT];
	assign fault_enable = ctrl_r[mss_pkg::CTRL_FAULT_EN +: mss_pkg::FAULT_W];

	// ----------------------------------------------------------------
	// transition conditions
	// ----------------------------------------------------------------
	logic                     supply_reset_eff;
	logic                     reset_condition;
	logic                     fault_condition;
	logic                     low_power_condition;
	logic                     low_power_exit_condition;
	logic                     all_paths_deactivated;
	logic [mss_pkg::LANES-1:0] path_deactivated;

	// absent supply detector reads as never asserted
	assign supply_reset_eff = HAS_SUPPLY_RESET & supply_reset_s; // see RULE6
	assign reset_condition = supply_reset_eff | ~hw_reset_n_s | soft_reset; // see RULE5
	// fault sources are chosen by software through the enable field
	assign fault_condition = |(fault_s & fault_enable); // see RULE8
	assign low_power_condition = sw_lp_req_bit
		| (pin_low_power_permit & low_power_pin_s); // see RULE9

	genvar gi;
	generate
		for (gi = 0; gi < mss_pkg::LANES; gi++) begin : g_lane
			assign path_deactivated[gi] =
				(lane_path_state[gi] == mss_pkg::PATH_DEACTIVATED); // see RULE11
		end
	endgenerate

	assign all_paths_deactivated    = &path_deactivated; // see RULE11
	assign low_power_exit_condition = low_power_condition & all_paths_deactivated; // see RULE10

	// ----------------------------------------------------------------
	// transient state timer
	// ----------------------------------------------------------------
	logic                      tmr_done;
	logic                      tmr_start;
	logic [mss_pkg::TMR_W-1:0] tmr_load;

	function automatic logic [mss_pkg::TMR_W-1:0] state_time(
		input mss_pkg::mss_state_t s
	);
		case (s)
			mss_pkg::st_resetting:      state_time = mss_pkg::CYC_RESETTING;
			mss_pkg::st_interface_init: state_time = mss_pkg::CYC_INIT;
			mss_pkg::st_powering_up:    state_time = mss_pkg::CYC_PWR_UP;
			mss_pkg::st_powering_down:  state_time = mss_pkg::CYC_PWR_DN;
			default:                    state_time = '0;
		endcase
	endfunction

	function automatic logic notice_state(input mss_pkg::mss_state_t s);
		notice_state = (s == mss_pkg::st_fault) || (s == mss_pkg::st_low_power)
			|| (s == mss_pkg::st_ready);
	endfunction

	assign tmr_start = (state_nxt != state_r);
	assign tmr_load  = state_time(state_nxt);
	mss_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (tmr_start),
		.load    (tmr_load),
		.done    (tmr_done)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mss_pkg::st_resetting: begin
				if (tmr_done)
					state_nxt = mss_pkg::st_reset; // see RULE12
			end
			mss_pkg::st_reset: begin
				if (!reset_condition)
					state_nxt = mss_pkg::st_interface_init; // see RULE3
			end
			mss_pkg::st_interface_init: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE4
				else if (fault_condition)
					state_nxt = mss_pkg::st_fault;
				else if (tmr_done)
					state_nxt = mss_pkg::st_low_power;
			end
			mss_pkg::st_low_power: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE4
				else if (fault_condition)
					state_nxt = mss_pkg::st_fault;
				else if (!low_power_condition)
					state_nxt = mss_pkg::st_powering_up; // see RULE13
			end
			mss_pkg::st_powering_up: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE4
				else if (fault_condition)
					state_nxt = mss_pkg::st_fault;
				else if (low_power_condition)
					state_nxt = mss_pkg::st_powering_down; // see RULE13
				else if (tmr_done)
					state_nxt = mss_pkg::st_ready; // see RULE13
			end
			mss_pkg::st_ready: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE4
				else if (fault_condition)
					state_nxt = mss_pkg::st_fault;
				else if (low_power_exit_condition)
					state_nxt = mss_pkg::st_powering_down; // see RULE14
			end
			mss_pkg::st_powering_down: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE4
				else if (fault_condition)
					state_nxt = mss_pkg::st_fault;
				else if (tmr_done)
					state_nxt = mss_pkg::st_low_power; // see RULE14
			end
			mss_pkg::st_fault: begin
				if (reset_condition)
					state_nxt = mss_pkg::st_resetting; // see RULE12
			end
			default: state_nxt = mss_pkg::st_resetting;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_r <= mss_pkg::st_reset; // see RULE3
		else
			state_r <= state_nxt; // see RULE16
	end

	// marks the first cycle in a newly entered state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			entered_r <= 1'b0;
		else
			entered_r <= (state_nxt != state_r);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_cond_q_r <= 1'b0;
		else
			fault_cond_q_r <= fault_condition;
	end

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	// notice waits one cycle so a state left at once is never flagged
	logic                      ev_notice;
	logic                      ev_fault;
	logic [mss_pkg::INT_W-1:0] ev_vec;
	assign ev_notice = entered_r && notice_state(state_r) // see RULE1
		&& (state_nxt == state_r); // see RULE2
	assign ev_fault  = fault_condition & ~fault_cond_q_r;

	always_comb begin
		ev_vec = '0;
		ev_vec[mss_pkg::INT_NOTICE] = ev_notice;
		ev_vec[mss_pkg::INT_FAULT]  = ev_fault;
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic setup_ph;
	logic wr_acc;
	logic mapped;
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == mss_pkg::OFF_CTRL) || (a == mss_pkg::OFF_STATE)
			|| (a == mss_pkg::OFF_INT_STATUS) || (a == mss_pkg::OFF_INT_CLEAR)
			|| (a == mss_pkg::OFF_INT_ENABLE);
	endfunction

	assign setup_ph = psel & ~penable;
	assign mapped   = addr_mapped(paddr);
	// writes land at the access edge that completes the transfer
	assign wr_acc   = psel & penable & pready & pwrite & mapped;

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	// one wait-free access cycle: ready is registered from setup and high in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				mss_pkg::OFF_CTRL:       prdata <= ctrl_r;
				mss_pkg::OFF_STATE: begin
					prdata[mss_pkg::STATE_CODE +: 3] <= state_r; // see RULE16
					prdata[mss_pkg::STATE_RESET_C]   <= reset_condition;
					prdata[mss_pkg::STATE_FAULT_C]   <= fault_condition;
					prdata[mss_pkg::STATE_LP_C]      <= low_power_condition;
					prdata[mss_pkg::STATE_LPEX_C]    <= low_power_exit_condition;
					prdata[mss_pkg::STATE_ALL_DEAC]  <= all_paths_deactivated;
				end
				mss_pkg::OFF_INT_STATUS: prdata[mss_pkg::INT_W-1:0] <= int_status_r;
				mss_pkg::OFF_INT_ENABLE: prdata[mss_pkg::INT_W-1:0] <= int_enable_r;
				default:                 prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// soft reset self-clears once the reset state is reached
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= mss_pkg::CTRL_RESET;
		end else if (wr_acc && paddr == mss_pkg::OFF_CTRL) begin
			ctrl_r <= pwdata;
			ctrl_r[31:mss_pkg::CTRL_FAULT_EN + mss_pkg::FAULT_W] <= '0;
			ctrl_r[3] <= 1'b0;
		end else if (state_r == mss_pkg::st_reset) begin
			ctrl_r[mss_pkg::CTRL_SOFT_RESET] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, enable, output
	// ----------------------------------------------------------------
	// a new event in the clearing cycle survives: set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_status_r <= '0;
		else if (wr_acc && paddr == mss_pkg::OFF_INT_CLEAR)
			int_status_r <= (int_status_r & ~pwdata[mss_pkg::INT_W-1:0]) | ev_vec; // see RULE15
		else
			int_status_r <= int_status_r | ev_vec; // see RULE15
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_enable_r <= mss_pkg::INT_EN_RESET;
		else if (wr_acc && paddr == mss_pkg::OFF_INT_ENABLE)
			int_enable_r <= pwdata[mss_pkg::INT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_status_r & int_enable_r); // see RULE15
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			module_state <= 3'h1;
		else
			module_state <= state_nxt; // see RULE16
	end

endmodule // mss_top

// File: design/mss_pkg.sv
// module state sequencer: shared constants, register map and state type
// assumes a 200 MHz pclk and a 32-bit APB register bus
package mss_pkg;

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		st_resetting,
		st_reset,
		st_interface_init,
		st_low_power,
		st_powering_up,
		st_ready,
		st_powering_down,
		st_fault
	} mss_state_t;

	// ----------------------------------------------------------------
	// lanes
	// ----------------------------------------------------------------
	localparam int          LANES            = 8;
	localparam int          PATH_W           = 4;
	localparam int          FAULT_W          = 4;
	localparam logic [3:0]  PATH_DEACTIVATED = 4'h1;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_STATE      = 8'h04;
	localparam logic [7:0]  OFF_INT_STATUS = 8'h08;
	localparam logic [7:0]  OFF_INT_CLEAR  = 8'h0c;
	localparam logic [7:0]  OFF_INT_ENABLE = 8'h10;

	// ctrl fields
	localparam int          CTRL_SOFT_RESET = 0;
	localparam int          CTRL_SW_LP      = 1;
	localparam int          CTRL_LP_PERMIT  = 2;
	localparam int          CTRL_FAULT_EN   = 4;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_00f4;

	// state register fields
	localparam int          STATE_CODE     = 0;
	localparam int          STATE_RESET_C  = 4;
	localparam int          STATE_FAULT_C  = 5;
	localparam int          STATE_LP_C     = 6;
	localparam int          STATE_LPEX_C   = 7;
	localparam int          STATE_ALL_DEAC = 8;

	// interrupt bits
	localparam int          INT_W          = 2;
	localparam int          INT_NOTICE     = 0;
	localparam int          INT_FAULT      = 1;
	localparam logic [1:0]  INT_EN_RESET   = 2'h0;

	// ----------------------------------------------------------------
	// timing of transient states
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_PS  = 5000;
	localparam int          T_RESETTING_NS = 1000;
	localparam int          T_INIT_NS      = 2000;
	localparam int          T_PWR_UP_NS    = 5000;
	localparam int          T_PWR_DN_NS    = 5000;
	localparam int          TMR_W          = 12;
	localparam logic [11:0] CYC_RESETTING  = 12'((T_RESETTING_NS * 1000) / CLK_PERIOD_PS);
	localparam logic [11:0] CYC_INIT       = 12'((T_INIT_NS * 1000) / CLK_PERIOD_PS);
	localparam logic [11:0] CYC_PWR_UP     = 12'((T_PWR_UP_NS * 1000) / CLK_PERIOD_PS);
	localparam logic [11:0] CYC_PWR_DN     = 12'((T_PWR_DN_NS * 1000) / CLK_PERIOD_PS);

endpackage

// File: design/mss_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is a slow level, not a pulse shorter than two clocks
`timescale 1ns/1ps
module mss_sync #(
	parameter int          W     = 1,
	parameter logic [31:0] INIT  = 32'h0000_0000
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r   <= INIT[W-1:0];
			sync_out <= INIT[W-1:0];
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // mss_sync

// File: design/mss_timer.sv
// completion timer for transient states
// assumes start is a one-cycle pulse; a new start reloads the count
`timescale 1ns/1ps
module mss_timer (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// control
	input  wire logic                     start,
	input  wire logic [mss_pkg::TMR_W-1:0] load,
	// result
	output logic                          done
);

	logic [mss_pkg::TMR_W-1:0] cnt_r;
	logic                      run_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (start) begin
			cnt_r <= load;
			run_r <= 1'b1;
		end else if (run_r && cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end else begin
			run_r <= 1'b0;
		end
	end

	// one-cycle pulse once the count has run out and no new start came
	assign done = run_r && (cnt_r == '0);

endmodule // mss_timer

// File: sim/mss_properties.sv
// concurrent checks on the ports of the module state sequencer
// assumes one pclk domain; presetn is asynchronous and active low
`timescale 1ns/1ps
module mss_properties #(
	parameter bit HAS_SUPPLY_RESET = 1'b1
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// reset sources, lanes and state
	input wire logic        hw_reset_n,
	input wire logic        supply_reset,
	input wire logic [mss_pkg::LANES-1:0][mss_pkg::PATH_W-1:0] lane_path_state,
	input wire logic [2:0]  module_state
);
	// ----
	// helpers
	// ----
	logic [2:0] rst_cnt_r;
	logic       all_deac;

	// saturating count of cycles with a raw reset source held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_cnt_r <= 3'h0;
		else if (!hw_reset_n || (HAS_SUPPLY_RESET && supply_reset))
			rst_cnt_r <= (rst_cnt_r == 3'h7) ? rst_cnt_r : rst_cnt_r + 3'h1;
		else
			rst_cnt_r <= 3'h0;
	end

	always_comb begin
		all_deac = 1'b1;
		for (int i = 0; i < mss_pkg::LANES; i++)
			if (lane_path_state[i] != mss_pkg::PATH_DEACTIVATED)
				all_deac = 1'b0;
	end

	// one bit per state that may follow state s
	function automatic logic [7:0] next_ok(input logic [2:0] s);
		case (s)
			3'h0: next_ok = 8'h03;
			3'h1: next_ok = 8'h06;
			3'h2: next_ok = 8'h8d;
			3'h3: next_ok = 8'h99;
			3'h4: next_ok = 8'hf1;
			3'h5: next_ok = 8'he1;
			3'h6: next_ok = 8'hc9;
			default: next_ok = 8'h81;
		endcase
	endfunction

	// ----
	// assertions
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_setup_answer: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_unmapped_err: assert property (pready && !pwrite && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_reset_entry: assert property (rst_cnt_r >= 3'h4 |-> module_state inside {3'h0, 3'h1})
		else $error("reset source ignored");
	chk_reset_hold: assert property (module_state == 3'h1 && rst_cnt_r >= 3'h3 |=> module_state == 3'h1)
		else $error("left reset while reset held");
	chk_state_legal: assert property ($changed(module_state) |-> ((next_ok($past(module_state)) >> module_state) & 8'h01) == 8'h01)
		else $error("illegal state transition");
	chk_powerdown_cause: assert property (module_state == 3'h5 ##1 module_state == 3'h6 |-> $past(all_deac))
		else $error("power down with active lanes");
endmodule // mss_properties

bind mss_top mss_properties #(.HAS_SUPPLY_RESET(HAS_SUPPLY_RESET)) mss_properties_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.hw_reset_n(hw_reset_n), .supply_reset(supply_reset),
	.lane_path_state(lane_path_state), .module_state(module_state));

// File: sim/mss_host_model.sv
// host side of the sequencer: drives the reset and low-power pins
// assumes requests from the bench change just after a rising pclk edge
`timescale 1ns/1ps
module mss_host_model #(
	parameter int MIN_PULSE = 8
) (
	// clock
	input wire logic pclk,
	// requests
	input wire logic reset_req,
	input wire logic lp_req,
	// pins
	output logic     hw_reset_n,
	output logic     low_power_pin
);
	int   hold_r = 0;
	logic rst_n_r = 1'b0;
	logic lp_r = 1'b1;

	// a short request still gives a pulse beyond the minimum width
	always @(posedge pclk) begin
		if (reset_req) begin
			rst_n_r <= 1'b0;
			hold_r <= MIN_PULSE;
		end else if (hold_r != 0)
			hold_r <= hold_r - 1;
		else
			rst_n_r <= 1'b1;
		lp_r <= lp_req;
	end
	assign hw_reset_n = rst_n_r;
	assign low_power_pin = lp_r;
endmodule // mss_host_model

// File: sim/test_module_state_sequencer.sv
// self-checking bench for the module state sequencer
// assumes the host model drives the pins; the bench drives apb and internal sources
`timescale 1ns/1ps
module test_module_state_sequencer;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hw_reset_n;
	logic        low_power_pin;
	logic        reset_req = 1'b1;
	logic        lp_req = 1'b1;
	logic        supply_reset = 1'b0;
	logic [3:0]  fault_src = 4'h0;
	logic [mss_pkg::LANES-1:0][mss_pkg::PATH_W-1:0] lanes = {mss_pkg::LANES{mss_pkg::PATH_DEACTIVATED}};
	logic [2:0]  module_state;
	logic        irq;
	logic [31:0] r;
	logic        e;
	int          fail_count = 0;
	int          n_checks = 0;

	always #2.5 pclk = ~pclk;

	mss_host_model mss_host_model_i (.pclk(pclk), .reset_req(reset_req), .lp_req(lp_req),
		.hw_reset_n(hw_reset_n), .low_power_pin(low_power_pin));
	mss_top mss_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_reset_n(hw_reset_n), .low_power_pin(low_power_pin),
		.supply_reset(supply_reset), .fault_src(fault_src), .lane_path_state(lanes),
		.module_state(module_state), .irq(irq));

	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// every task starts and ends just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			chk(32'h0, 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r & m, exp);
	endtask

	// waits while the state is still 'from', then expects 'to'
	task automatic ws(input logic [2:0] from, input logic [2:0] to);
		int n;
		n = 0;
		while (module_state === from && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk({29'h0, module_state}, {29'h0, to});
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		conclude();
	end

	// ----
	// tests
	// ----
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({29'h0, module_state}, 32'h1);
		repeat (297) @(posedge pclk);
		chk({29'h0, module_state}, 32'h1);
		rd(8'h04, 32'h117, 32'h111);
		rd(8'h00, 32'hffffffff, mss_pkg::CTRL_RESET);
		rd(8'h10, 32'hffffffff, 32'h0);
		rd(8'h14, 32'hffffffff, 32'h0);
		chk({31'h0, e}, 32'h1);
		reset_req <= 1'b0;
		ws(3'h1, 3'h2);
		ws(3'h2, 3'h3);
		rd(8'h08, 32'h1, 32'h1);
		apb(1'b1, 8'h08, 32'h0);
		rd(8'h08, 32'h1, 32'h1);
		apb(1'b1, 8'h10, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h10, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(8'h08, 32'h1, 32'h1);
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h0c, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(8'h08, 32'h1, 32'h0);
		$display("test power-up and interrupt done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 8'h00, {28'h000000f, 1'b0, i[1], i[0], 1'b0});
			lp_req <= i[2];
			repeat (6) @(posedge pclk);
			rd(8'h04, 32'h1c0, {23'h0, 1'b1, {2{i[0] | (i[1] & i[2])}}, 6'h0});
		end
		apb(1'b1, 8'h00, 32'hf4);
		ws(3'h6, 3'h3);
		$display("test low-power condition done");
		lanes[7] <= 4'h2;
		apb(1'b1, 8'h0c, 32'h3);
		lp_req <= 1'b0;
		ws(3'h3, 3'h4);
		ws(3'h4, 3'h5);
		rd(8'h08, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h0c, 32'h1);
		lp_req <= 1'b1;
		repeat (50) @(posedge pclk);
		chk({29'h0, module_state}, 32'h5);
		rd(8'h04, 32'h1c0, 32'h040);
		lanes[7] <= mss_pkg::PATH_DEACTIVATED;
		ws(3'h5, 3'h6);
		lp_req <= 1'b0;
		ws(3'h6, 3'h3);
		ws(3'h3, 3'h4);
		rd(8'h08, 32'h1, 32'h0);
		lp_req <= 1'b1;
		ws(3'h4, 3'h6);
		ws(3'h6, 3'h3);
		rd(8'h08, 32'h1, 32'h1);
		$display("test power sequence done");
		rd(8'h04, 32'h10, 32'h0);
		for (int i = 1; i < 8; i++) begin
			supply_reset <= i[0];
			reset_req <= i[1];
			if (i[2])
				apb(1'b1, 8'h00, 32'hf5);
			repeat (4) @(posedge pclk);
			rd(8'h04, 32'h10, 32'h10);
			supply_reset <= 1'b0;
			reset_req <= 1'b0;
			ws(3'h0, 3'h1);
			ws(3'h1, 3'h2);
			ws(3'h2, 3'h3);
		end
		$display("test reset sources done");
		reset_req <= 1'b1;
		@(posedge pclk);
		fault_src <= 4'h2;
		ws(3'h3, 3'h0);
		fault_src <= 4'h0;
		reset_req <= 1'b0;
		ws(3'h0, 3'h1);
		ws(3'h1, 3'h2);
		ws(3'h2, 3'h3);
		apb(1'b1, 8'h00, 32'h04);
		fault_src <= 4'hf;
		repeat (20) @(posedge pclk);
		rd(8'h04, 32'h27, 32'h03);
		apb(1'b1, 8'h0c, 32'h3);
		apb(1'b1, 8'h00, 32'h14);
		ws(3'h3, 3'h7);
		rd(8'h08, 32'h3, 32'h3);
		reset_req <= 1'b1;
		ws(3'h7, 3'h0);
		fault_src <= 4'h0;
		reset_req <= 1'b0;
		ws(3'h0, 3'h1);
		$display("test fault and priority done");
		conclude();
	end
endmodule // test_module_state_sequencer
